// ### src/host_pin_pkg.sv
/*
  Package for the host bus mode pin control block: shared types and constants.
  Assumes one system clock at 25 MHz and an active-low asynchronous reset.
*/
package host_pin_pkg;

  localparam int unsigned CTRL_RTS_BIT = 1;
  localparam int unsigned CTRL_OUT2_BIT = 3;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic RST_SYNC_LEN_ONE = 1'b1;

  // decoded host access, one per cycle
  typedef struct packed {
    logic sel_a;
    logic sel_b;
    logic rd;
    logic wr;
  } host_access_s;

  // per-channel pin state
  typedef struct packed {
    logic [7:0] modem_ctrl_reg;
    logic ring_q;
    logic msi_pend;
  } chan_state_s;

endpackage

// ### src/chan_modem_pins.sv
/*
  One channel of modem control: holds the modem control register, detects
  the ring edge and raises the modem-status pending flag.
  Assumes inputs synchronous to i_clk_sys and a qualified internal reset.
*/
`timescale 1ns/1ps
module chan_modem_pins (
  input wire logic i_clk_sys,                         // system clock
  input wire logic i_nrst,                            // async reset, active low
  input wire logic i_dev_rst,                         // master reset, decoded
  input wire logic i_ctrl_we,                         // write modem control reg
  input wire logic [7:0] i_ctrl_wdata,                // new modem control value
  input wire logic i_msi_en,                          // modem-status irq enable
  input wire logic i_msi_clr,                         // clear pending flag
  input wire logic i_ring_n,                          // ring indicator, active low
  output host_pin_pkg::chan_state_s o_state           // current channel state
);
  import host_pin_pkg::*;

  chan_state_s st_q, st_d;

  always_comb begin
    st_d = st_q;
    if (i_ctrl_we) begin
      st_d.modem_ctrl_reg = i_ctrl_wdata;
    end
    st_d.ring_q = i_ring_n;
    if (i_msi_clr) begin
      st_d.msi_pend = 1'b0;
    end
    // set beats clear so an edge in the clear cycle survives
    if (i_msi_en && i_ring_n && !st_q.ring_q) begin
      st_d.msi_pend = 1'b1;
    end
    if (i_dev_rst) begin
      st_d.modem_ctrl_reg = CTRL_RESET;
      st_d.msi_pend = 1'b0;
      st_d.ring_q = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q <= '{modem_ctrl_reg: CTRL_RESET, ring_q: 1'b1, msi_pend: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign o_state = st_q;

  chk_ring_edge_sets: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (!i_dev_rst && i_msi_en && i_ring_n && !st_q.ring_q) |=> st_q.msi_pend)
    else $error("ring rising edge did not set pending");
  chk_no_edge_no_set: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (!st_q.msi_pend && !(i_msi_en && i_ring_n && !st_q.ring_q)) |=> !st_q.msi_pend)
    else $error("pending set without enabled ring edge");
  cov_ring_irq: cover property (@(posedge i_clk_sys) disable iff (!i_nrst)
    $rose(st_q.msi_pend));

endmodule

// ### src/host_bus_mode_pin_control.sv
/*
  Top of the host bus mode pin control block: mode select, chip-select and
  strobe decode, reset polarity, interrupt pin and modem output pins.
  Assumes all inputs synchronous to i_clk_sys; board pulls an open pin high.
*/
// What this block does
// - Strobe mode: A's control bit 3 drives irq A and lowers user out A, else both idle.
// - Strobe mode: the second irq pin is B's irq, gated by B's control bit 3 alike.
// - Mode select low: first irq pin is one active-low open-drain device interrupt.
// - Mode select low: second irq pin is unused and left undriven.
// - Read strobe is an active-low read in strobe mode and ignored in direction mode.
// - Mode select high: the shared input is an active-low write strobe.
// - Mode select low: the shared input is a direction line, high read and low write.
// - Mode select high: the master reset input is active high.
// - Mode select low: the master reset input is active low.
// - A rising edge on a channel's ring input raises a modem-status irq when enabled.
// - Control bit 1 set lowers request-to-send, clear raises it; high after reset.
// - Mode select low: first chip select picks both channels, else each picks its own.
// - Mode select low: second chip select is address line 3, low A and high B.
`timescale 1ns/1ps
module host_bus_mode_pin_control (
  input wire logic i_clk_sys,                // system clock, 25 MHz
  input wire logic i_nrst,                   // async reset, active low
  input wire logic i_bus_mode_sel,           // 1/open: strobe mode, 0: direction mode
  input wire logic i_master_reset,           // master reset, polarity by mode
  input wire logic i_chip_sel_first,         // chip select A / both
  input wire logic i_chip_sel_second,        // chip select B / address 3
  input wire logic i_read_strobe_n,          // read strobe, strobe mode only
  input wire logic i_write_strobe_n,         // write strobe / direction line
  input wire logic [7:0] i_ctrl_wdata,       // modem control write data
  input wire logic i_ctrl_addr,              // access targets modem control reg
  input wire logic i_msi_clr,                // clear modem-status pending, selected chan
  input wire logic [1:0] i_msi_en,           // modem-status irq enable per channel
  input wire logic i_chan_a_ring_n,          // channel A ring indicator
  input wire logic i_chan_b_ring_n,          // channel B ring indicator
  output logic o_chan_a_irq_out,             // irq A / device irq level
  output logic o_chan_a_irq_oe_n,            // irq A pin enable, low drives
  output logic o_chan_b_irq_out,             // irq B level
  output logic o_chan_b_irq_oe_n,            // irq B pin enable, low drives
  output logic o_chan_a_user_out_n,          // user output A
  output logic o_chan_b_user_out_n,          // user output B
  output logic o_chan_a_req_send_n,          // request to send A
  output logic o_chan_b_req_send_n,          // request to send B
  output logic o_strobe_mode,                // captured mode strap
  output logic o_dev_rst,                    // decoded master reset
  output host_pin_pkg::host_access_s o_access // decoded host access
);
  import host_pin_pkg::*;

  typedef struct packed {
    logic strap_done;
    logic strobe_mode;
    logic dev_rst;
    host_access_s acc;
    logic prev_act;
    logic a_irq;
    logic a_oe_n;
    logic b_irq;
    logic b_oe_n;
    logic a_op2_n;
    logic b_op2_n;
    logic a_rts_n;
    logic b_rts_n;
  } top_state_s;

  localparam top_state_s TOP_RESET = '{strap_done: 1'b0, strobe_mode: 1'b1,
    dev_rst: 1'b0, acc: '0, prev_act: 1'b0, a_irq: 1'b0, a_oe_n: 1'b1,
    b_irq: 1'b0, b_oe_n: 1'b1, a_op2_n: 1'b1, b_op2_n: 1'b1,
    a_rts_n: 1'b1, b_rts_n: 1'b1};

  top_state_s st_q, st_d;
  chan_state_s cha, chb;
  host_access_s acc;
  logic act;
  logic we_a, we_b;
  logic mode_now;

  // before the strap is caught the reset value of the mode would misread the reset pin
  assign mode_now = st_q.strap_done ? st_q.strobe_mode : i_bus_mode_sel;

  // combinational host decode on the current mode
  always_comb begin
    acc = '0;
    if (st_q.strobe_mode) begin
      acc.sel_a = !i_chip_sel_first;
      acc.sel_b = !i_chip_sel_second;
      acc.rd = !i_read_strobe_n;
      acc.wr = !i_write_strobe_n;
    end else begin
      acc.sel_a = !i_chip_sel_first && !i_chip_sel_second;
      acc.sel_b = !i_chip_sel_first && i_chip_sel_second;
      acc.rd = !i_chip_sel_first && i_write_strobe_n;
      acc.wr = !i_chip_sel_first && !i_write_strobe_n; // read strobe ignored
    end
  end

  // one write per access: act on the leading edge of the strobe
  assign act = acc.wr && i_ctrl_addr;
  assign we_a = act && !st_q.prev_act && acc.sel_a;
  assign we_b = act && !st_q.prev_act && acc.sel_b;

  chan_modem_pins u_chan_a (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_dev_rst(st_q.dev_rst),
    .i_ctrl_we(we_a),
    .i_ctrl_wdata(i_ctrl_wdata),
    .i_msi_en(i_msi_en[0]),
    .i_msi_clr(i_msi_clr && acc.sel_a),
    .i_ring_n(i_chan_a_ring_n),
    .o_state(cha)
  );

  chan_modem_pins u_chan_b (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_dev_rst(st_q.dev_rst),
    .i_ctrl_we(we_b),
    .i_ctrl_wdata(i_ctrl_wdata),
    .i_msi_en(i_msi_en[1]),
    .i_msi_clr(i_msi_clr && acc.sel_b),
    .i_ring_n(i_chan_b_ring_n),
    .o_state(chb)
  );

  always_comb begin
    st_d = st_q;
    // strap caught once after reset release; an open pin is pulled high
    if (!st_q.strap_done) begin
      st_d.strap_done = 1'b1;
      st_d.strobe_mode = i_bus_mode_sel;
    end
    st_d.dev_rst = mode_now ? i_master_reset : !i_master_reset;
    st_d.acc = acc;
    st_d.prev_act = act;
    st_d.a_op2_n = !cha.modem_ctrl_reg[CTRL_OUT2_BIT];
    st_d.b_op2_n = !chb.modem_ctrl_reg[CTRL_OUT2_BIT];
    st_d.a_rts_n = !cha.modem_ctrl_reg[CTRL_RTS_BIT];
    st_d.b_rts_n = !chb.modem_ctrl_reg[CTRL_RTS_BIT];
    if (st_q.strobe_mode) begin
      // active-high irq per channel, floated when gated off
      st_d.a_irq = cha.msi_pend;
      st_d.a_oe_n = !cha.modem_ctrl_reg[CTRL_OUT2_BIT];
      st_d.b_irq = chb.msi_pend;
      st_d.b_oe_n = !chb.modem_ctrl_reg[CTRL_OUT2_BIT];
    end else begin
      // open drain: only ever drives low
      st_d.a_irq = 1'b0;
      st_d.a_oe_n = !(cha.msi_pend || chb.msi_pend);
      st_d.b_irq = 1'b0;
      st_d.b_oe_n = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q <= TOP_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_chan_a_irq_out = st_q.a_irq;
  assign o_chan_a_irq_oe_n = st_q.a_oe_n;
  assign o_chan_b_irq_out = st_q.b_irq;
  assign o_chan_b_irq_oe_n = st_q.b_oe_n;
  assign o_chan_a_user_out_n = st_q.a_op2_n;
  assign o_chan_b_user_out_n = st_q.b_op2_n;
  assign o_chan_a_req_send_n = st_q.a_rts_n;
  assign o_chan_b_req_send_n = st_q.b_rts_n;
  assign o_strobe_mode = st_q.strobe_mode;
  assign o_dev_rst = st_q.dev_rst;
  assign o_access = st_q.acc;

  chk_irq_a_gate: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (st_q.strap_done && st_q.strobe_mode) |=> (o_chan_a_irq_oe_n == o_chan_a_user_out_n))
    else $error("irq A enable and user output disagree");
  chk_irq_b_gate: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (st_q.strobe_mode && !chb.modem_ctrl_reg[CTRL_OUT2_BIT]) |=> o_chan_b_irq_oe_n)
    else $error("irq B driven while gated off");
  chk_dev_irq_od: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (!st_q.strobe_mode && !$past(st_q.strobe_mode)) |-> !o_chan_a_irq_out)
    else $error("device irq drove high");
  chk_irq_b_unused: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (st_q.strap_done && !st_q.strobe_mode) |=> o_chan_b_irq_oe_n)
    else $error("second irq pin driven in direction mode");
  chk_dev_irq_any: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (!st_q.strobe_mode && (cha.msi_pend || chb.msi_pend)) |=> !o_chan_a_irq_oe_n)
    else $error("device irq missing with pending channel");
  chk_rd_ignored: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (!st_q.strobe_mode && !i_write_strobe_n) |-> !acc.rd)
    else $error("read decoded with direction low");
  chk_rst_pol: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (st_q.strap_done && $stable(st_q.strobe_mode))
      |=> (o_dev_rst == (o_strobe_mode ? $past(i_master_reset) : !$past(i_master_reset))))
    else $error("master reset polarity wrong");
  chk_rts_follow: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    we_a && !st_q.dev_rst
      |=> ##1 (o_chan_a_req_send_n == !$past(i_ctrl_wdata[CTRL_RTS_BIT], 2)))
    else $error("request to send A does not follow write");
  chk_rts_b_follow: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    we_b && !st_q.dev_rst
      |=> ##1 (o_chan_b_req_send_n == !$past(i_ctrl_wdata[CTRL_RTS_BIT], 2)))
    else $error("request to send B does not follow write");
  chk_user_a_follow: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    we_a && !st_q.dev_rst
      |=> ##1 (o_chan_a_user_out_n == !$past(i_ctrl_wdata[CTRL_OUT2_BIT], 2)))
    else $error("user output A does not follow write");
  chk_sel_addr3: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (!st_q.strobe_mode && !i_chip_sel_first)
      |=> (o_access.sel_b == $past(i_chip_sel_second) && o_access.sel_a != o_access.sel_b))
    else $error("address 3 does not pick the channel");
  chk_wr_strobe: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (st_q.strobe_mode && !i_write_strobe_n && !i_chip_sel_first)
      |=> (o_access.wr && o_access.sel_a))
    else $error("write strobe not decoded");

  cov_strobe_write: cover property (@(posedge i_clk_sys) disable iff (!i_nrst)
    st_q.strobe_mode && we_b);
  cov_dir_write: cover property (@(posedge i_clk_sys) disable iff (!i_nrst)
    !st_q.strobe_mode && we_a);
  cov_dev_irq: cover property (@(posedge i_clk_sys) disable iff (!i_nrst)
    !st_q.strobe_mode && $fell(o_chan_a_irq_oe_n));

endmodule

// ### tb/modem_board_model.sv
/*
  Far-side model: modem ring lines and board wiring of both irq pins.
  Assumes the bench raises ring requests between clock edges.
*/
`timescale 1ns/1ps
module modem_board_model (
  input wire logic i_clk_sys,         // system clock
  input wire logic [1:0] i_ring_req,  // hold ring active, bit0 A
  input wire logic i_irq_a,           // irq A level
  input wire logic i_irq_a_oe_n,      // irq A enable, low drives
  input wire logic i_irq_b,           // irq B level
  input wire logic i_irq_b_oe_n,      // irq B enable, low drives
  output logic o_ring_a_n,            // ring A, active low
  output logic o_ring_b_n,            // ring B, active low
  output logic o_pin_a,               // resolved irq A wire
  output logic o_pin_b                // resolved irq B wire
);
  logic last_b = 1'b0;
  initial begin
    o_ring_a_n = 1'b1;
    o_ring_b_n = 1'b1;
  end
  // release of the request gives the rising edge the device reacts to
  always @(posedge i_clk_sys) begin
    o_ring_a_n <= ~i_ring_req[0];
    o_ring_b_n <= ~i_ring_req[1];
    if (!i_irq_b_oe_n) begin
      last_b <= i_irq_b;
    end
  end
  // pull-up on pin A: a released open-drain or 3-state pin reads high
  assign o_pin_a = i_irq_a_oe_n ? 1'b1 : i_irq_a;
  // no pull-up on pin B: released, it shows the opposite of its last level
  assign o_pin_b = i_irq_b_oe_n ? ~last_b : i_irq_b;
endmodule

// ### tb/tb_host_bus_mode_pin_control.sv
/*
  Bench for the host bus mode pin control block, both bus modes.
  Assumes modem_board_model stands for the modem and the board wiring.
*/
`timescale 1ns/1ps
module tb_host_bus_mode_pin_control;
  import host_pin_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, mode = 1'b1, mrst = 1'b0, clr = 1'b0;
  logic cs1 = 1'b1, cs2 = 1'b1, rd_n = 1'b1, wr_n = 1'b1, maddr = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [1:0] msi_en = 2'h0, ring_req = 2'h0;
  logic ring_a_n, ring_b_n, irq_a, oe_a, irq_b, oe_b, user_a, user_b;
  logic rts_a, rts_b, smode, dev_rst, pin_a, pin_b;
  host_access_s acc, seen;
  int n_errors = 0, n_checks = 0, cyc = 0;
  always #20 clk = ~clk;
  host_bus_mode_pin_control i_host_bus_mode_pin_control (
    .i_clk_sys(clk), .i_nrst(nrst), .i_bus_mode_sel(mode), .i_master_reset(mrst),
    .i_chip_sel_first(cs1), .i_chip_sel_second(cs2), .i_read_strobe_n(rd_n),
    .i_write_strobe_n(wr_n), .i_ctrl_wdata(wdata), .i_ctrl_addr(maddr),
    .i_msi_clr(clr), .i_msi_en(msi_en), .i_chan_a_ring_n(ring_a_n),
    .i_chan_b_ring_n(ring_b_n), .o_chan_a_irq_out(irq_a), .o_chan_a_irq_oe_n(oe_a),
    .o_chan_b_irq_out(irq_b), .o_chan_b_irq_oe_n(oe_b), .o_chan_a_user_out_n(user_a),
    .o_chan_b_user_out_n(user_b), .o_chan_a_req_send_n(rts_a),
    .o_chan_b_req_send_n(rts_b), .o_strobe_mode(smode), .o_dev_rst(dev_rst),
    .o_access(acc));
  modem_board_model i_modem_board_model (
    .i_clk_sys(clk), .i_ring_req(ring_req), .i_irq_a(irq_a), .i_irq_a_oe_n(oe_a),
    .i_irq_b(irq_b), .i_irq_b_oe_n(oe_b), .o_ring_a_n(ring_a_n),
    .o_ring_b_n(ring_b_n), .o_pin_a(pin_a), .o_pin_b(pin_b));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one host cycle, then idle long enough for the pins to follow
  task automatic access(input logic c1, c2, r, w, input logic [7:0] d);
    @(negedge clk);
    cs1 = c1;
    cs2 = c2;
    rd_n = r;
    wr_n = w;
    maddr = 1'b1;
    wdata = d;
    @(negedge clk);
    seen = acc;
    cs1 = 1'b1;
    cs2 = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    maddr = 1'b0;
    repeat (3) @(negedge clk);
  endtask
  task automatic ring(input logic [1:0] ch);
    @(negedge clk);
    ring_req = ch;
    repeat (2) @(negedge clk);
    ring_req = 2'h0;
    repeat (4) @(negedge clk);
  endtask
  task automatic restart(input logic m, input logic mr);
    @(negedge clk);
    nrst = 1'b0;
    mode = m;
    mrst = mr;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    check(dev_rst, m ? mr : !mr);
    @(negedge clk);
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // whole run needs about 76 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_errors++;
      close_out();
    end
  end
  initial begin
    restart(1'b1, 1'b0);
    check(smode, 1'b1);
    check({rts_a, rts_b, user_a, user_b, oe_a, oe_b}, 8'h3f);
    // channel A: bit 3 gates the irq and lowers user out, bit 1 lowers RTS
    access(1'b0, 1'b1, 1'b1, 1'b0, 8'h0a);
    check({rts_a, user_a, oe_a, rts_b, user_b, oe_b}, 8'h07);
    check(seen, 8'h09);
    access(1'b1, 1'b0, 1'b1, 1'b0, 8'h08);
    check({rts_b, user_b, oe_b, rts_a}, 8'h08);
    access(1'b1, 1'b0, 1'b0, 1'b1, 8'h00);
    check({seen, oe_b}, 8'h0c);
    msi_en = 2'h1;
    ring(2'h3);
    check({irq_a, pin_a, irq_b}, 8'h06);
    msi_en = 2'h3;
    ring(2'h2);
    check({irq_b, pin_b}, 8'h03);
    @(negedge clk);
    clr = 1'b1;
    cs1 = 1'b0;
    @(negedge clk);
    clr = 1'b0;
    cs1 = 1'b1;
    repeat (3) @(negedge clk);
    check({irq_a, irq_b}, 8'h01);
    mrst = 1'b1;
    repeat (2) @(negedge clk);
    check(dev_rst, 1'b1);
    mrst = 1'b0;
    repeat (3) @(negedge clk);
    check({rts_a, user_a, oe_b, irq_b}, 8'h0e);
    restart(1'b0, 1'b1);
    check({smode, dev_rst, oe_b}, 8'h01);
    access(1'b0, 1'b1, 1'b1, 1'b0, 8'h02);
    check({seen, rts_a, rts_b, oe_b}, 8'h2d);
    access(1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
    check(seen, 8'h09);
    access(1'b0, 1'b0, 1'b1, 1'b1, 8'h00);
    check(seen, 8'h0a);
    ring(2'h1);
    check({oe_a, irq_a, pin_a, oe_b, irq_b}, 8'h02);
    mrst = 1'b0;
    repeat (2) @(negedge clk);
    mrst = 1'b1;
    repeat (3) @(negedge clk);
    check({rts_b, oe_a, pin_a}, 8'h07);
    close_out();
  end
endmodule
